// File: rtl/csrc_consts.svh
// constants for the chip-select read cycle sequencer
`ifndef CSRC_CONSTS_SVH
`define CSRC_CONSTS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define CSRC_ADDR_W     23
`define CSRC_DATA_W     16
`define CSRC_WS_W       4
`define CSRC_CS_N       2
`define CSRC_SYNC_W     18

// ----------------------------------------------------------------
// values and counts
// ----------------------------------------------------------------
`define CSRC_WS_ZERO    4'h0
`define CSRC_TURN_CLKS  2'h2
`define CSRC_TURN_ZERO  2'h0
`define CSRC_CS_IDLE    2'h3
`define CSRC_WARM_CLKS  2'h3
`define CSRC_ADDR_STEP  23'h000001

`endif

// File: rtl/csrc_pkg.sv
// types shared by the chip-select read cycle sequencer
package csrc_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSRC_IDLE,
    CSRC_START,
    CSRC_S0,
    CSRC_S1,
    CSRC_S2,
    CSRC_S3,
    CSRC_S4,
    CSRC_S5
  } csrc_state_e;

endpackage

// File: rtl/csrc_pin_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module csrc_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;   // first stage, read only by second
  logic [W-1:0] sync_reg;   // second stage

  // ----------------------------------------------------------------
  // two flip-flops per bit
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

// File: rtl/csrc_read_cycle.sv
// chip-select read cycle sequencer, bus master side
`timescale 1ns/1ps
`include "csrc_consts.svh"
module csrc_read_cycle
  import csrc_pkg::*;
(
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  // requester side
  input  wire logic                      req_i,
  input  wire logic [`CSRC_ADDR_W-1:0]   req_addr_i,
  input  wire logic                      req_long_i,
  input  wire logic                      req_region_i,
  input  wire logic [`CSRC_WS_W-1:0]     wait_count_field_i,
  input  wire logic                      auto_ack_i,
  output logic                           req_ready_o,
  output logic [2*`CSRC_DATA_W-1:0]      rd_data_o,
  output logic                           rd_done_o,
  output logic                           wr_turn_ok_o,
  // external bus side
  input  wire logic                      bus_clk_i,
  output logic [`CSRC_ADDR_W-1:0]        addr_o,
  output logic                           addr_oe_n_o,
  output logic                           rw_o,
  output logic                           rw_oe_n_o,
  output logic [`CSRC_CS_N-1:0]          cs_n_o,
  output logic                           rd_strobe_n_o,
  input  wire logic                      cycle_done_ack_n_i,
  input  wire logic [`CSRC_DATA_W-1:0]   data_i,
  output logic [`CSRC_DATA_W-1:0]        data_o,
  output logic                           data_oe_n_o
);

  // ----------------------------------------------------------------
  // pin synchronisation and bus clock edges
  // ----------------------------------------------------------------
  logic [`CSRC_SYNC_W-1:0] pin_sync;    // {bus clock, ack, data}
  logic                    bclk_s;      // synced bus clock
  logic                    ack_n_s;     // synced acknowledge
  logic [`CSRC_DATA_W-1:0] data_s;      // synced read data
  logic                    bclk_d_reg;  // delayed bus clock
  logic                    rise;        // bus clock rising edge
  logic                    fall;        // bus clock falling edge
  logic [1:0]              warm_reg;    // clocks since reset, edges ignored until full
  logic [1:0]              warm_next;   // next warm-up count

  // pins pass two flops; data and clock share latency so they stay aligned
  csrc_pin_sync #(
    .W (`CSRC_SYNC_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    ({bus_clk_i, cycle_done_ack_n_i, data_i}),
    .sync_o     (pin_sync)
  );

  assign bclk_s  = pin_sync[`CSRC_SYNC_W-1];
  assign ack_n_s = pin_sync[`CSRC_DATA_W];
  assign data_s  = pin_sync[`CSRC_DATA_W-1:0];
  assign rise    = bclk_s & ~bclk_d_reg & (warm_reg == `CSRC_WARM_CLKS);
  assign fall    = ~bclk_s & bclk_d_reg & (warm_reg == `CSRC_WARM_CLKS);

  // sync flops and edge flop hold reset zeros for a few clocks; a bus clock
  // pin already high would otherwise look like a rising edge right after reset
  always_comb begin
    warm_next = warm_reg;
    if (warm_reg != `CSRC_WARM_CLKS) begin
      warm_next = warm_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  csrc_state_e                state_reg, state_next;       // bus state
  logic [`CSRC_ADDR_W-1:0]    addr_reg, addr_next;         // latched address
  logic                       long_reg, long_next;         // longword pending
  logic                       hi_reg, hi_next;             // high word in flight
  logic                       region_reg, region_next;     // selected region
  logic [`CSRC_WS_W-1:0]      ws_reg, ws_next;             // programmed waits
  logic [`CSRC_WS_W-1:0]      wcnt_reg, wcnt_next;         // waits left
  logic                       auto_reg, auto_next;         // auto-ack for region
  logic                       drive_reg, drive_next;       // address/rw driven
  logic                       strobe_reg, strobe_next;     // select and read on
  logic [2*`CSRC_DATA_W-1:0]  data_reg, data_next;         // captured word
  logic                       done_reg, done_next;         // completion pulse
  logic [1:0]                 turn_reg, turn_next;         // turnaround clocks
  logic                       ack_seen;                    // ack at this edge
  logic                       take;                        // request accepted

  // wait counter load value when starting an access
  function automatic logic [`CSRC_WS_W-1:0] wait_load(input logic [`CSRC_WS_W-1:0] ws);
    wait_load = ws;
  endfunction

  // accept while idle, or on the ending edge of a finished read
  assign take = req_i & ((state_reg == CSRC_IDLE) |
                ((state_reg == CSRC_S5) & rise & ~long_reg));

  // internal ack once waits run out, or slave ack after waits
  assign ack_seen = (wcnt_reg == `CSRC_WS_ZERO) & (auto_reg | ~ack_n_s);

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    addr_next   = addr_reg;
    long_next   = long_reg;
    hi_next     = hi_reg;
    region_next = region_reg;
    ws_next     = ws_reg;
    wcnt_next   = wcnt_reg;
    auto_next   = auto_reg;
    drive_next  = drive_reg;
    strobe_next = strobe_reg;
    data_next   = data_reg;
    done_next   = 1'b0;
    turn_next   = turn_reg;
    // turnaround counts bus clocks after a read ends
    if (rise && turn_reg != `CSRC_TURN_ZERO) begin
      turn_next = turn_reg - 2'h1;
    end
    // latch a new request
    if (take) begin
      addr_next   = req_addr_i;
      long_next   = req_long_i;
      hi_next     = req_long_i;
      region_next = req_region_i;
      ws_next     = wait_count_field_i;
      auto_next   = auto_ack_i;
    end
    case (state_reg)
      // nothing on the bus
      CSRC_IDLE: begin
        if (take) begin
          state_next = CSRC_START;
        end
      end
      // wait for a rising edge to open S0
      CSRC_START: begin
        if (rise) begin
          state_next = CSRC_S0;
          drive_next = 1'b1;
          wcnt_next  = wait_load(ws_reg);
        end
      end
      // address valid; select follows on falling edge
      CSRC_S0: begin
        if (fall) begin
          state_next  = CSRC_S1;
          strobe_next = 1'b1;
        end
      end
      // select and read asserted
      CSRC_S1: begin
        if (rise) begin
          state_next = CSRC_S2;
        end
      end
      // data phase first half
      CSRC_S2: begin
        if (fall) begin
          state_next = CSRC_S3;
        end
      end
      // sample data with ack, else whole-clock waits
      CSRC_S3: begin
        if (rise) begin
          if (ack_seen) begin
            state_next = CSRC_S4;
            if (hi_reg) begin
              data_next[2*`CSRC_DATA_W-1:`CSRC_DATA_W] = data_s;
            end else begin
              data_next[`CSRC_DATA_W-1:0] = data_s;
              done_next = 1'b1;
            end
          end else if (wcnt_reg != `CSRC_WS_ZERO) begin
            wcnt_next = wcnt_reg - 4'h1;
          end
        end
      end
      // ack negated; strobes drop on next falling edge
      CSRC_S4: begin
        if (fall) begin
          state_next  = CSRC_S5;
          strobe_next = 1'b0;
        end
      end
      // ending rising edge releases bus or starts next access
      CSRC_S5: begin
        if (rise) begin
          turn_next = `CSRC_TURN_CLKS;
          if (long_reg && hi_reg) begin
            state_next = CSRC_S0;
            hi_next    = 1'b0;
            long_next  = 1'b0;
            addr_next  = addr_reg + `CSRC_ADDR_STEP;
            wcnt_next  = wait_load(ws_reg);
          end else if (take) begin
            state_next = CSRC_S0;
            wcnt_next  = wait_load(wait_count_field_i);
          end else begin
            state_next = CSRC_IDLE;
            drive_next = 1'b0;
          end
        end
      end
      default: begin
        state_next = CSRC_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bclk_d_reg <= 1'b0;
      warm_reg   <= '0;
      state_reg  <= CSRC_IDLE;
      addr_reg   <= '0;
      long_reg   <= 1'b0;
      hi_reg     <= 1'b0;
      region_reg <= 1'b0;
      ws_reg     <= `CSRC_WS_ZERO;
      wcnt_reg   <= `CSRC_WS_ZERO;
      auto_reg   <= 1'b0;
      drive_reg  <= 1'b0;
      strobe_reg <= 1'b0;
      data_reg   <= '0;
      done_reg   <= 1'b0;
      turn_reg   <= `CSRC_TURN_ZERO;
    end else begin
      bclk_d_reg <= bclk_s;
      warm_reg   <= warm_next;
      state_reg  <= state_next;
      addr_reg   <= addr_next;
      long_reg   <= long_next;
      hi_reg     <= hi_next;
      region_reg <= region_next;
      ws_reg     <= ws_next;
      wcnt_reg   <= wcnt_next;
      auto_reg   <= auto_next;
      drive_reg  <= drive_next;
      strobe_reg <= strobe_next;
      data_reg   <= data_next;
      done_reg   <= done_next;
      turn_reg   <= turn_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign req_ready_o   = (state_reg == CSRC_IDLE) |
                         ((state_reg == CSRC_S5) & rise & ~long_reg);
  assign rd_data_o     = data_reg;
  assign rd_done_o     = done_reg;
  assign wr_turn_ok_o  = (turn_reg == `CSRC_TURN_ZERO) & ~drive_reg;
  assign addr_o        = addr_reg;
  assign addr_oe_n_o   = ~drive_reg;
  assign rw_o          = 1'b1;
  assign rw_oe_n_o     = ~drive_reg;
  // one select per region, low-true
  assign cs_n_o[0]     = ~(strobe_reg & ~region_reg);
  assign cs_n_o[1]     = ~(strobe_reg & region_reg);
  assign rd_strobe_n_o = ~strobe_reg;
  // read-only sequencer never drives the data bus
  assign data_o        = '0;
  assign data_oe_n_o   = 1'b1;

endmodule

// File: test/csrc_read_cycle_asserts.sv
// checker of the read sequencer's pin and handshake timing
`timescale 1ns/1ps
module csrc_read_cycle_asserts (
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       req_ready_o,
  input wire logic       rd_done_o,
  input wire logic       bus_clk_i,
  input wire logic       addr_oe_n_o,
  input wire logic       rw_o,
  input wire logic       rw_oe_n_o,
  input wire logic [1:0] cs_n_o,
  input wire logic       rd_strobe_n_o,
  input wire logic       data_oe_n_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // address phase opens, a select follows half a bus clock later
  sequence addr_up; $fell(addr_oe_n_o); endsequence
  sequence sel_on; cs_n_o != 2'h3; endsequence
  reset_idle_a: assert property (disable iff (1'b0) rst_i |=> cs_n_o == 2'h3
    && rd_strobe_n_o && addr_oe_n_o) else $error("bus not idle in reset");
  sel_after_a: assert property (addr_up |-> (cs_n_o == 2'h3)[*4] ##[1:10] sel_on)
    else $error("select not half a clock after address");
  strobe_pair_a: assert property (rd_strobe_n_o == &cs_n_o)
    else $error("read strobe apart from select");
  sel_fall_a: assert property ($changed(cs_n_o) |-> !bus_clk_i)
    else $error("select moved off a falling bus edge");
  addr_rise_a: assert property ($changed(addr_oe_n_o) |-> bus_clk_i)
    else $error("address drive moved off a rising bus edge");
  addr_held_a: assert property (sel_on |-> !addr_oe_n_o && !rw_oe_n_o && rw_o)
    else $error("address or direction loose while selected");
  no_write_a: assert property (data_oe_n_o)
    else $error("data bus driven by reader");
  busy_refuse_a: assert property (sel_on |-> !req_ready_o)
    else $error("request taken mid cycle");
  done_pulse_a: assert property (rd_done_o |-> sel_on ##1 !rd_done_o)
    else $error("done pulse outside select or too long");
endmodule
bind csrc_read_cycle csrc_read_cycle_asserts i_chk (
  .core_clk_i    (core_clk_i),
  .rst_i         (rst_i),
  .req_ready_o   (req_ready_o),
  .rd_done_o     (rd_done_o),
  .bus_clk_i     (bus_clk_i),
  .addr_oe_n_o   (addr_oe_n_o),
  .rw_o          (rw_o),
  .rw_oe_n_o     (rw_oe_n_o),
  .cs_n_o        (cs_n_o),
  .rd_strobe_n_o (rd_strobe_n_o),
  .data_oe_n_o   (data_oe_n_o)
);

// File: test/csrc_slave_model.sv
// slave memory answering chip-select reads on the external bus
`timescale 1ns/1ps
`include "csrc_consts.svh"
module csrc_slave_model (
  input  wire logic                    bus_clk_i,
  input  wire logic                    sel_n_i,   // own select, low-true
  input  wire logic [`CSRC_ADDR_W-1:0] addr_i,
  input  wire logic                    ack_en_i,  // slave gives the ack
  input  wire logic [3:0]              delay_i,   // clocks before ack
  output logic                         ack_n_o,
  output logic [`CSRC_DATA_W-1:0]      data_o
);
  logic        drv = 1'b0;  // data driven
  logic        fin = 1'b0;  // word handed over
  int          cnt = 0;     // selected falling edges
  logic [15:0] pat;
  initial ack_n_o = 1'b1;
  assign pat = addr_i[15:0] ^ 16'h5A3C;
  // released bus shows the inverse, never a held value
  assign data_o = (drv && !sel_n_i) ? pat : ~pat;
  // slave reacts on falling edges only
  always @(negedge bus_clk_i) begin
    if (sel_n_i || fin) begin
      drv <= 1'b0;
      ack_n_o <= 1'b1;
      fin <= !sel_n_i;
      cnt <= 0;
    end else begin
      drv <= 1'b1;
      cnt <= cnt + 1;
      if (ack_en_i && cnt >= delay_i) begin
        ack_n_o <= 1'b0;
        fin <= 1'b1;
      end
    end
  end
endmodule

// File: test/testbench.sv
// self-checking bench for the chip-select read cycle sequencer
`timescale 1ns/1ps
`include "csrc_consts.svh"
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %0t %s", $time, m); end end
module testbench;
  logic core_clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, req_long_i = 1'b0;
  logic req_region_i = 1'b0, auto_ack_i = 1'b0, bus_clk_i = 1'b0;
  logic [`CSRC_ADDR_W-1:0] req_addr_i = 23'h000000, addr_o;
  logic [3:0] wait_count_field_i = 4'h0, dly = 4'h0;
  logic req_ready_o, rd_done_o, wr_turn_ok_o, addr_oe_n_o, rw_o, rw_oe_n_o;
  logic rd_strobe_n_o, data_oe_n_o, cycle_done_ack_n_i, ack_en = 1'b0;
  logic [31:0] rd_data_o;
  logic [1:0] cs_n_o;
  logic [`CSRC_DATA_W-1:0] data_o, data_i;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  csrc_read_cycle i_csrc_read_cycle (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i), .req_addr_i(req_addr_i),
    .req_long_i(req_long_i), .req_region_i(req_region_i),
    .wait_count_field_i(wait_count_field_i), .auto_ack_i(auto_ack_i),
    .req_ready_o(req_ready_o), .rd_data_o(rd_data_o), .rd_done_o(rd_done_o),
    .wr_turn_ok_o(wr_turn_ok_o), .bus_clk_i(bus_clk_i), .addr_o(addr_o),
    .addr_oe_n_o(addr_oe_n_o), .rw_o(rw_o), .rw_oe_n_o(rw_oe_n_o), .cs_n_o(cs_n_o),
    .rd_strobe_n_o(rd_strobe_n_o), .cycle_done_ack_n_i(cycle_done_ack_n_i),
    .data_i(data_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o));
  csrc_slave_model i_csrc_slave_model (.bus_clk_i(bus_clk_i), .sel_n_i(&cs_n_o),
    .addr_i(addr_o), .ack_en_i(ack_en), .delay_i(dly), .ack_n_o(cycle_done_ack_n_i),
    .data_o(data_i));
  always #2.5 core_clk_i = ~core_clk_i;
  // bus clock at 80 ns, phase apart from the core clock
  initial begin #1.3; forever #40 bus_clk_i = ~bus_clk_i; end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 30000) begin n_mismatch++; wrap_up(); end
  end
  task automatic wrap_up();
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [15:0] pat(input logic [22:0] a);
    return a[15:0] ^ 16'h5A3C;
  endfunction
  // one read; wt = slave ack delay in clocks
  task automatic do_read(input logic [22:0] a, input logic lng, rg, input logic [3:0] ws,
                         input logic au, input int wt);
    int lo, oth, sp, nd, n, e;
    lo = 0; oth = 0; sp = 0; nd = 0; n = 0;
    e = (lng ? 2 : 1) * (2 + ws + wt) * 16;
    @(negedge core_clk_i);
    req_i = 1'b1; req_addr_i = a; req_long_i = lng; req_region_i = rg;
    wait_count_field_i = ws; auto_ack_i = au;
    while (req_ready_o !== 1'b1) @(negedge core_clk_i);
    @(negedge core_clk_i);
    req_i = 1'b0;
    while (!(nd > 0 && cs_n_o === 2'h3) && n < 3000) begin
      if (cs_n_o[rg] === 1'b0) lo++;
      if (cs_n_o[!rg] === 1'b0) oth++;
      if (lo > 0) sp++;
      if (rd_done_o === 1'b1) begin
        nd++;
        if (lng) `CHK(rd_data_o, {pat(a), pat(a + 1)}, "long data")
        else `CHK(rd_data_o[15:0], pat(a), "word data")
        `CHK(rw_o, 1'b1, "direction not read")
      end
      @(negedge core_clk_i);
      n++;
    end
    `CHK(nd == 1, 1'b1, "done count")
    `CHK(lo >= e - 2 && lo <= e + 2, 1'b1, "select time")
    `CHK(sp <= e + (lng ? 18 : 2), 1'b1, "gap between words")
    `CHK(oth == 0, 1'b1, "wrong region")
  endtask
  task automatic t_reset_idle();
    `CHK(cs_n_o, `CSRC_CS_IDLE, "select idle")
    `CHK(rd_strobe_n_o, 1'b1, "strobe idle")
    `CHK(data_oe_n_o, 1'b1, "data floats")
    `CHK(addr_oe_n_o, 1'b1, "address idle")
    `CHK(rw_oe_n_o, 1'b1, "direction idle")
    `CHK(rd_done_o, 1'b0, "done idle")
    `CHK(wr_turn_ok_o, 1'b1, "turnaround idle")
    `CHK(data_o, 16'h0000, "write data idle")
  endtask
  task automatic t_auto_waits();
    do_read(23'h000120, 1'b0, 1'b0, 4'h0, 1'b1, 0);
    do_read(23'h001357, 1'b0, 1'b1, 4'h1, 1'b1, 0);
    do_read(23'h7FFFFF, 1'b0, 1'b1, 4'hF, 1'b1, 0);
  endtask
  task automatic t_slave_ack();
    ack_en = 1'b1;
    dly = 4'h0;
    do_read(23'h00F0F0, 1'b0, 1'b0, 4'h0, 1'b0, 0);
    dly = 4'h3;
    do_read(23'h00A5A5, 1'b0, 1'b0, 4'h0, 1'b0, 3);
    ack_en = 1'b0;
  endtask
  task automatic t_long_turn();
    int k;
    k = 0;
    do_read(23'h00ABCE, 1'b1, 1'b1, 4'h2, 1'b1, 0);
    `CHK(wr_turn_ok_o, 1'b0, "turnaround early")
    while (wr_turn_ok_o !== 1'b1 && k < 200) begin @(negedge core_clk_i); k++; end
    `CHK(k >= 20 && k <= 60, 1'b1, "turnaround time")
  endtask
  task automatic t_mid_reset();
    int n;
    n = 0;
    @(negedge core_clk_i);
    req_i = 1'b1; auto_ack_i = 1'b1; wait_count_field_i = 4'h4;
    while (req_ready_o !== 1'b1) @(negedge core_clk_i);
    @(negedge core_clk_i);
    req_i = 1'b0;
    while (cs_n_o === 2'h3 && n < 200) begin @(negedge core_clk_i); n++; end
    `CHK(n < 200, 1'b1, "select before reset")
    rst_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    `CHK(cs_n_o, `CSRC_CS_IDLE, "select after reset")
    `CHK(addr_oe_n_o, 1'b1, "address after reset")
    rst_i = 1'b0;
  endtask
  initial begin
    repeat (6) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_reset_idle();
    t_auto_waits();
    t_slave_ack();
    t_mid_reset();
    t_long_turn();
    wrap_up();
  end
endmodule
